// ---- core/scbc_top.sv ----
// Function
// - Device is only an SMBus target answering a 7-bit address plus direction bit.
// - Block write: index N, count X, X data bytes to N..N+X-1; every byte acked.
// - Block read: index written, repeated start, count then bytes; host nacks last.
// - Address upper bits are 1101; lower bits from tri-level strap latched at power-up.
// - Enable bit 1 lets pin control output; 0 forces byte 11 stop state.
// - Byte 1 bits 7:6 read back the PLL mode latched from bandwidth strap.
// - Byte 1 bit 5 picks mode source: latched value or byte 1 bits 4:3.
// - Byte 2 holds per-output slew bits at 7,6,4,3,2,0; 1 fast, reset 1.
// - Byte 3 bit 5 enables software frequency select via bits 4:3, reset 0.
// - Byte 3 bit 0 sets feedback slew, 1 fast, reset 1.
// - Byte 11 bits 1:0: 00 low/low, 01 hiz, 10 high/low, 11 low/high.
// - Frequency select bits act only while byte 3 bit 5 is set.
module scbc_top (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // SMBus link, open drain data
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Power-up straps, 00 low, 01 mid, 10 high
  input  wire logic [1:0] address_strap_trilevel,
  input  wire logic [1:0] bandwidth_strap_trilevel,
  // External output enable pins, active low
  input  wire logic [5:0] out_enable_pin_n,
  // Controls to the clock path
  output logic [5:0]      out_active,
  output logic [5:0]      out_edge_speed,
  output logic            feedback_edge_speed,
  output logic [1:0]      swing_sel,
  output logic [1:0]      pll_mode,
  output logic            freq_sel_valid,
  output logic [1:0]      freq_sel,
  output logic            stop_hiz,
  output logic            stop_true_high,
  output logic            stop_comp_high
);

  // Pick the six output bits out of a byte laid out as 7,6,4,3,2,0
  function automatic logic [5:0] pick6(input logic [7:0] b);
    pick6 = {b[7], b[6], b[4], b[3], b[2], b[0]};
  endfunction : pick6

  // Masked register update; unwritable bits keep their value
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] data,
                                         input logic [7:0] mask);
    wr_byte = (old & ~mask) | (data & mask);
  endfunction : wr_byte

  // Link domain: bits are sampled on the host's own clock edge
  logic [7:0] link_shift_r;
  logic [7:0] link_shift_nxt;

  always_comb begin
    link_shift_nxt = {link_shift_r[6:0], sda_i};
  end

  always_ff @(posedge scl or posedge reset) begin
    if (reset) begin
      link_shift_r <= 8'h00;
    end else begin
      link_shift_r <= link_shift_nxt;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  logic       scl_m1, scl_m2, scl_m3;
  logic       sda_m1, sda_m2, sda_m3;
  logic [5:0] pin_m1, pin_m2;
  logic [1:0] adr_m1, adr_m2, bw_m1, bw_m2;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      scl_m1 <= 1'b1;
      scl_m2 <= 1'b1;
      scl_m3 <= 1'b1;
      sda_m1 <= 1'b1;
      sda_m2 <= 1'b1;
      sda_m3 <= 1'b1;
      pin_m1 <= 6'h3F;
      pin_m2 <= 6'h3F;
      adr_m1 <= 2'h0;
      adr_m2 <= 2'h0;
      bw_m1  <= 2'h0;
      bw_m2  <= 2'h0;
    end else if (clk_en) begin
      scl_m1 <= scl;
      scl_m2 <= scl_m1;
      scl_m3 <= scl_m2;
      sda_m1 <= sda_i;
      sda_m2 <= sda_m1;
      sda_m3 <= sda_m2;
      pin_m1 <= out_enable_pin_n;
      pin_m2 <= pin_m1;
      adr_m1 <= address_strap_trilevel;
      adr_m2 <= adr_m1;
      bw_m1  <= bandwidth_strap_trilevel;
      bw_m2  <= bw_m1;
    end
  end

  // Bus events seen from the synchronised lines
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_m2 & ~scl_m3;
  assign scl_fall  = ~scl_m2 & scl_m3;
  assign bus_start = scl_m2 & scl_m3 & sda_m3 & ~sda_m2;
  assign bus_stop  = scl_m2 & scl_m3 & ~sda_m3 & sda_m2;

  // Strap capture once the synchronisers have settled after reset
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic       strap_done_r, strap_done_nxt;
  logic [2:0] addr_lo_r, addr_lo_nxt;
  logic [1:0] pll_latch_r, pll_latch_nxt;

  always_comb begin
    strap_cnt_nxt  = strap_cnt_r;
    strap_done_nxt = strap_done_r;
    addr_lo_nxt    = addr_lo_r;
    pll_latch_nxt  = pll_latch_r;
    if (!strap_done_r) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      if (strap_cnt_r == scbc_pkg::STRAP_SETTLE) begin
        strap_done_nxt = 1'b1;
        pll_latch_nxt  = bw_m2;
        case (adr_m2)
          scbc_pkg::STRAP_LOW: addr_lo_nxt = scbc_pkg::ADDR_LO_LOW;
          scbc_pkg::STRAP_MID: addr_lo_nxt = scbc_pkg::ADDR_LO_MID;
          default:             addr_lo_nxt = scbc_pkg::ADDR_LO_HIGH;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
      addr_lo_r    <= 3'h0;
      pll_latch_r  <= 2'h0;
    end else if (clk_en) begin
      strap_cnt_r  <= strap_cnt_nxt;
      strap_done_r <= strap_done_nxt;
      addr_lo_r    <= addr_lo_nxt;
      pll_latch_r  <= pll_latch_nxt;
    end
  end

  // Protocol engine and configuration bytes
  scbc_pkg::scbc_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] idx_r, idx_nxt, remain_r, remain_nxt, tx_r, tx_nxt;
  logic       oe_r, oe_nxt;
  logic [7:0] out_en_r, out_en_nxt, pll_amp_r, pll_amp_nxt, slew_r, slew_nxt;
  logic [7:0] freq_r, freq_nxt, stop_r, stop_nxt;
  logic [7:0] rx_byte, rd_byte;
  logic       addr_hit, tx_mode;

  // The shifter only moves on scl rise, so after a seen fall it is quiet for half a bit
  assign rx_byte  = link_shift_r;
  assign addr_hit = (rx_byte[7:1] == {scbc_pkg::ADDR_HI, addr_lo_r});
  assign tx_mode  = (state_r == scbc_pkg::ST_RCOUNT) || (state_r == scbc_pkg::ST_RDATA);

  // Read data; reserved bits follow their printed values
  always_comb begin
    case (idx_r)
      scbc_pkg::REG_OUT_EN:  rd_byte = out_en_r & scbc_pkg::WMASK_OUT_EN;
      scbc_pkg::REG_PLL_AMP: rd_byte = {pll_latch_r, pll_amp_r[5:0]} | scbc_pkg::FIXED_PLL_AMP;
      scbc_pkg::REG_SLEW:    rd_byte = slew_r | scbc_pkg::FIXED_SLEW;
      scbc_pkg::REG_FREQ:    rd_byte = freq_r | scbc_pkg::FIXED_FREQ;
      scbc_pkg::REG_STOP:    rd_byte = stop_r | scbc_pkg::FIXED_STOP;
      default:               rd_byte = 8'h00;
    endcase
  end

  // Next state of the engine; a start anywhere restarts the frame
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    idx_nxt     = idx_r;
    remain_nxt  = remain_r;
    tx_nxt      = tx_r;
    oe_nxt      = oe_r;
    out_en_nxt  = out_en_r;
    pll_amp_nxt = pll_amp_r;
    slew_nxt    = slew_r;
    freq_nxt    = freq_r;
    stop_nxt    = stop_r;
    if (bus_start) begin
      state_nxt   = scbc_pkg::ST_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_nxt      = 1'b0;
    end else if (bus_stop) begin
      state_nxt   = scbc_pkg::ST_IDLE;
      bit_cnt_nxt = 4'h0;
      oe_nxt      = 1'b0;
    end else if (state_r != scbc_pkg::ST_IDLE) begin
      if (scl_rise) begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
        // Host nack on a sent byte ends the read
        if (tx_mode && bit_cnt_r == scbc_pkg::BIT_ACK && sda_m2) begin
          state_nxt = scbc_pkg::ST_SKIP;
        end
      end else if (scl_fall && bit_cnt_r == scbc_pkg::BIT_ACK) begin
        case (state_r)
          scbc_pkg::ST_ADDR: begin
            if (addr_hit && strap_done_r) begin
              oe_nxt    = 1'b1;
              state_nxt = rx_byte[0] ? scbc_pkg::ST_RCOUNT : scbc_pkg::ST_INDEX;
            end else begin
              state_nxt = scbc_pkg::ST_SKIP;
            end
          end
          scbc_pkg::ST_INDEX: begin
            oe_nxt    = 1'b1;
            idx_nxt   = rx_byte;
            state_nxt = scbc_pkg::ST_COUNT;
          end
          scbc_pkg::ST_COUNT: begin
            oe_nxt     = 1'b1;
            remain_nxt = rx_byte;
            state_nxt  = scbc_pkg::ST_WDATA;
          end
          scbc_pkg::ST_WDATA: begin
            oe_nxt = 1'b1;
            // Bytes past the count are acked but dropped
            if (remain_r != 8'h00) begin
              remain_nxt = remain_r - 8'h01;
              idx_nxt    = idx_r + 8'h01;
              case (idx_r)
                scbc_pkg::REG_OUT_EN:  out_en_nxt  = wr_byte(out_en_r, rx_byte, scbc_pkg::WMASK_OUT_EN);
                scbc_pkg::REG_PLL_AMP: pll_amp_nxt = wr_byte(pll_amp_r, rx_byte, scbc_pkg::WMASK_PLL_AMP);
                scbc_pkg::REG_SLEW:    slew_nxt    = wr_byte(slew_r, rx_byte, scbc_pkg::WMASK_SLEW);
                scbc_pkg::REG_FREQ:    freq_nxt    = wr_byte(freq_r, rx_byte, scbc_pkg::WMASK_FREQ);
                scbc_pkg::REG_STOP:    stop_nxt    = wr_byte(stop_r, rx_byte, scbc_pkg::WMASK_STOP);
                default:               stop_nxt    = stop_r;
              endcase
            end
          end
          scbc_pkg::ST_RCOUNT: begin
            oe_nxt    = 1'b0;
            state_nxt = scbc_pkg::ST_RDATA;
          end
          scbc_pkg::ST_RDATA: oe_nxt = 1'b0;
          default:            oe_nxt = 1'b0;
        endcase
      end else if (scl_fall && bit_cnt_r == scbc_pkg::BIT_ACK_END) begin
        bit_cnt_nxt = 4'h0;
        // Load the next byte to send, or release the ack
        if (state_r == scbc_pkg::ST_RCOUNT) begin
          tx_nxt = scbc_pkg::READ_COUNT;
          oe_nxt = ~scbc_pkg::READ_COUNT[7];
        end else if (state_r == scbc_pkg::ST_RDATA) begin
          tx_nxt  = rd_byte;
          oe_nxt  = ~rd_byte[7];
          idx_nxt = idx_r + 8'h01;
        end else begin
          oe_nxt = 1'b0;
        end
      end else if (scl_fall && tx_mode && bit_cnt_r != 4'h0) begin
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_nxt = ~tx_r[6];
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r   <= scbc_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      idx_r     <= 8'h00;
      remain_r  <= 8'h00;
      tx_r      <= 8'h00;
      oe_r      <= 1'b0;
      out_en_r  <= scbc_pkg::RST_OUT_EN;
      pll_amp_r <= scbc_pkg::RST_PLL_AMP;
      slew_r    <= scbc_pkg::RST_SLEW;
      freq_r    <= scbc_pkg::RST_FREQ;
      stop_r    <= scbc_pkg::RST_STOP;
    end else if (clk_en) begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      idx_r     <= idx_nxt;
      remain_r  <= remain_nxt;
      tx_r      <= tx_nxt;
      oe_r      <= oe_nxt;
      out_en_r  <= out_en_nxt;
      pll_amp_r <= pll_amp_nxt;
      slew_r    <= slew_nxt;
      freq_r    <= freq_nxt;
      stop_r    <= stop_nxt;
    end
  end

  // Open drain: only ever pull low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_r;

  // Registered controls to the clock path
  logic [5:0] act_r, act_nxt, edge_r, edge_nxt;
  logic [1:0] swing_r, swing_nxt, mode_r, mode_nxt, fsel_r, fsel_nxt;
  logic       fb_r, fb_nxt, fval_r, fval_nxt, hiz_r, hiz_nxt, th_r, th_nxt, ch_r, ch_nxt;

  always_comb begin
    act_nxt   = pick6(out_en_r) & ~pin_m2;
    edge_nxt  = pick6(slew_r);
    swing_nxt = pll_amp_r[scbc_pkg::AMP_LSB +: 2];
    mode_nxt  = pll_amp_r[scbc_pkg::PLL_SW_BIT] ? pll_amp_r[scbc_pkg::PLL_SET_LSB +: 2]
                                                : pll_latch_r;
    fval_nxt  = freq_r[scbc_pkg::FREQ_EN_BIT];
    fsel_nxt  = fval_nxt ? freq_r[scbc_pkg::FREQ_SEL_LSB +: 2] : 2'h0;
    fb_nxt    = freq_r[scbc_pkg::FB_SLEW_BIT];
    hiz_nxt   = stop_r[scbc_pkg::STOP_LSB +: 2] == scbc_pkg::STOP_HIZ;
    th_nxt    = stop_r[scbc_pkg::STOP_LSB +: 2] == scbc_pkg::STOP_HIGH_LOW;
    ch_nxt    = stop_r[scbc_pkg::STOP_LSB +: 2] == scbc_pkg::STOP_LOW_HIGH;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      act_r   <= 6'h00;
      edge_r  <= {scbc_pkg::RST_SLEW[7:6], scbc_pkg::RST_SLEW[4:2], scbc_pkg::RST_SLEW[0]};
      swing_r <= scbc_pkg::RST_PLL_AMP[scbc_pkg::AMP_LSB +: 2];
      mode_r  <= 2'h0;
      fval_r  <= 1'b0;
      fsel_r  <= 2'h0;
      fb_r    <= scbc_pkg::RST_FREQ[scbc_pkg::FB_SLEW_BIT];
      hiz_r   <= 1'b0;
      th_r    <= 1'b0;
      ch_r    <= 1'b0;
    end else if (clk_en) begin
      act_r   <= act_nxt;
      edge_r  <= edge_nxt;
      swing_r <= swing_nxt;
      mode_r  <= mode_nxt;
      fval_r  <= fval_nxt;
      fsel_r  <= fsel_nxt;
      fb_r    <= fb_nxt;
      hiz_r   <= hiz_nxt;
      th_r    <= th_nxt;
      ch_r    <= ch_nxt;
    end
  end

  assign out_active          = act_r;
  assign out_edge_speed      = edge_r;
  assign swing_sel           = swing_r;
  assign pll_mode            = mode_r;
  assign freq_sel_valid      = fval_r;
  assign freq_sel            = fsel_r;
  assign feedback_edge_speed = fb_r;
  assign stop_hiz            = hiz_r;
  assign stop_true_high      = th_r;
  assign stop_comp_high      = ch_r;

  // Checks on the management domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !clk_en);

  property p_addr_ack;
    (state_r == scbc_pkg::ST_ADDR) && scl_fall && !bus_start && bit_cnt_r == scbc_pkg::BIT_ACK
      && addr_hit && strap_done_r |=> sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Address match not acked");

  property p_addr_miss;
    (state_r == scbc_pkg::ST_ADDR) && scl_fall && !bus_start && bit_cnt_r == scbc_pkg::BIT_ACK
      && !addr_hit |=> !sda_oe && state_r == scbc_pkg::ST_SKIP;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("Foreign address was answered");

  property p_write_ack_release;
    (state_r == scbc_pkg::ST_WDATA) && scl_fall && !bus_start && !bus_stop
      && bit_cnt_r == scbc_pkg::BIT_ACK_END |=> !sda_oe && bit_cnt_r == 4'h0;
  endproperty
  a_write_ack_release: assert property (p_write_ack_release) else $error("Ack not released");

  property p_slew_write;
    (state_r == scbc_pkg::ST_WDATA) && scl_fall && !bus_start && !bus_stop && remain_r != 8'h00
      && bit_cnt_r == scbc_pkg::BIT_ACK && idx_r == scbc_pkg::REG_SLEW
      |=> slew_r == ($past(rx_byte) & scbc_pkg::WMASK_SLEW) ##1 out_edge_speed == pick6($past(slew_r));
  endproperty
  a_slew_write: assert property (p_slew_write) else $error("Slew byte write lost");

  property p_read_nack;
    tx_mode && scl_rise && !bus_start && !bus_stop && bit_cnt_r == scbc_pkg::BIT_ACK && sda_m2
      |=> state_r == scbc_pkg::ST_SKIP ##1 !sda_oe;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("Read went on after nack");

  property p_out_forced;
    !out_en_r[0] |=> !out_active[0];
  endproperty
  a_out_forced: assert property (p_out_forced) else $error("Disabled output still active");

  property p_reserved_zero;
    idx_r == scbc_pkg::REG_OUT_EN |-> rd_byte[5] == 1'b0 && rd_byte[1] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved enable bits read one");

  property p_pll_source;
    ##1 pll_mode == ($past(pll_amp_r[scbc_pkg::PLL_SW_BIT]) ? $past(pll_amp_r[scbc_pkg::PLL_SET_LSB +: 2])
                                                            : $past(pll_latch_r));
  endproperty
  a_pll_source: assert property (p_pll_source) else $error("PLL mode source wrong");

  property p_freq_gate;
    !freq_r[scbc_pkg::FREQ_EN_BIT] |=> !freq_sel_valid && freq_sel == 2'h0;
  endproperty
  a_freq_gate: assert property (p_freq_gate) else $error("Frequency select acted while disabled");

  property p_stop_hiz;
    stop_r[scbc_pkg::STOP_LSB +: 2] == scbc_pkg::STOP_HIZ |=> stop_hiz && !stop_true_high && !stop_comp_high;
  endproperty
  a_stop_hiz: assert property (p_stop_hiz) else $error("Stop state decode wrong");

  property p_fb_amp;
    ##1 feedback_edge_speed == $past(freq_r[scbc_pkg::FB_SLEW_BIT])
      && swing_sel == $past(pll_amp_r[scbc_pkg::AMP_LSB +: 2]);
  endproperty
  a_fb_amp: assert property (p_fb_amp) else $error("Feedback slew or swing wrong");

  c_write: cover property (state_r == scbc_pkg::ST_WDATA && bus_stop);
  c_read:  cover property (state_r == scbc_pkg::ST_RDATA ##[1:1000] state_r == scbc_pkg::ST_SKIP);
  c_miss:  cover property (state_r == scbc_pkg::ST_ADDR ##1 state_r == scbc_pkg::ST_SKIP);

endmodule : scbc_top

// ---- inc/scbc_pkg.sv ----
package scbc_pkg;

  // Register indices
  localparam logic [7:0] REG_OUT_EN  = 8'h00;
  localparam logic [7:0] REG_PLL_AMP = 8'h01;
  localparam logic [7:0] REG_SLEW    = 8'h02;
  localparam logic [7:0] REG_FREQ    = 8'h03;
  localparam logic [7:0] REG_STOP    = 8'h0B;

  // Writable bits of each register
  localparam logic [7:0] WMASK_OUT_EN  = 8'hDD;
  localparam logic [7:0] WMASK_PLL_AMP = 8'h3B;
  localparam logic [7:0] WMASK_SLEW    = 8'hDD;
  localparam logic [7:0] WMASK_FREQ    = 8'h39;
  localparam logic [7:0] WMASK_STOP    = 8'h03;

  // Reserved bits that read back as one
  localparam logic [7:0] FIXED_PLL_AMP = 8'h04;
  localparam logic [7:0] FIXED_SLEW    = 8'h22;
  localparam logic [7:0] FIXED_FREQ    = 8'hC6;
  localparam logic [7:0] FIXED_STOP    = 8'h40;

  // Reset values of the writable bits
  localparam logic [7:0] RST_OUT_EN  = 8'hDD;
  localparam logic [7:0] RST_PLL_AMP = 8'h02;
  localparam logic [7:0] RST_SLEW    = 8'hDD;
  localparam logic [7:0] RST_FREQ    = 8'h01;
  localparam logic [7:0] RST_STOP    = 8'h00;

  // Field positions
  localparam int PLL_SW_BIT   = 5;
  localparam int PLL_SET_LSB  = 3;
  localparam int AMP_LSB      = 0;
  localparam int FREQ_EN_BIT  = 5;
  localparam int FREQ_SEL_LSB = 3;
  localparam int FB_SLEW_BIT  = 0;
  localparam int STOP_LSB     = 0;

  // Stop-state encodings
  localparam logic [1:0] STOP_LOW_LOW  = 2'h0;
  localparam logic [1:0] STOP_HIZ      = 2'h1;
  localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
  localparam logic [1:0] STOP_LOW_HIGH = 2'h3;

  // Target address: fixed upper nibble, lower bits from the strap
  localparam logic [3:0] ADDR_HI      = 4'hD;
  localparam logic [1:0] STRAP_LOW    = 2'h0;
  localparam logic [1:0] STRAP_MID    = 2'h1;
  localparam logic [2:0] ADDR_LO_LOW  = 3'h0;
  localparam logic [2:0] ADDR_LO_MID  = 3'h1;
  localparam logic [2:0] ADDR_LO_HIGH = 3'h2;

  // Protocol constants
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [3:0] BIT_ACK_END    = 4'h9;
  localparam logic [7:0] READ_COUNT     = 8'h0C;
  localparam logic [1:0] STRAP_SETTLE   = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_RCOUNT, ST_RDATA, ST_SKIP
  } scbc_state_t;

endpackage : scbc_pkg

// ---- verif/scbc_host.sv ----
module scbc_host (
  // Bus lines toward the target
  output logic       scl,
  output logic       sda_pull_n,
  input  wire logic  sda_line,
  // Line levels seen during the last nine clocks
  output logic [8:0] rx_q
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;
  event rx_done;

  // Line released and clock standing high between frames
  initial begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
    rx_q = 9'h1FF;
  end

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    #20 sda_pull_n = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_pull_n = 1'b0;
    #HALF scl = 1'b0;
  endtask : start

  // Nine clocks, MSB first; data moves 20 ns after the fall to give hold time
  task automatic xfer(input logic [8:0] drv);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_pull_n = drv[i];
      #(HALF - 20) scl = 1'b1;
      #(HALF / 2) rx_q[i] = sda_line;
      #(HALF / 2) scl = 1'b0;
    end
    -> rx_done;
  endtask : xfer

  // Stop: data rises while the clock is high, then the clock stands still
  task automatic stop();
    #20 sda_pull_n = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_pull_n = 1'b1;
    #HALF;
  endtask : stop
endmodule : scbc_host

// ---- verif/tb_smbus_clock_buffer_config.sv ----
module tb_smbus_clock_buffer_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0]  tgt;   // Fixed 1101 over the strap's low bits
  logic [1:0]  adr_s; // Address strap, held stable across each reset
  localparam logic [7:0] WM[4] = '{8'hDD, 8'h3B, 8'hDD, 8'h39};
  localparam logic [7:0] FX[4] = '{8'h00, 8'h04, 8'h22, 8'hC6};
  localparam logic [1:0] BW = 2'h1;
  logic        mclk, reset, scl, sda_pull_n, sda_line, sda_o, sda_oe, fb, fv, s_hz, s_th, s_ch;
  logic [1:0]  swing, pll, fsel, stp;
  logic [5:0]  pins_n, active, speed;
  logic [8:0]  rx_q;
  logic [7:0]  sh[4];
  logic [7:0]  wbuf[4];
  logic [31:0] rng;
  logic [8:0]  exp_bus[$];
  logic [22:0] exp_port[$];
  int          n_mismatch, num_checks, cyc;
  event        snap;

  // Open-drain wire with pull-up
  assign sda_line = sda_pull_n & ~(sda_oe & ~sda_o);

  scbc_top uut (
    .mclk(mclk), .reset(reset), .clk_en(1'b1), .scl(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_strap_trilevel(adr_s), .bandwidth_strap_trilevel(BW), .out_enable_pin_n(pins_n),
    .out_active(active), .out_edge_speed(speed), .feedback_edge_speed(fb), .swing_sel(swing), .pll_mode(pll),
    .freq_sel_valid(fv), .freq_sel(fsel), .stop_hiz(s_hz), .stop_true_high(s_th), .stop_comp_high(s_ch));

  scbc_host host (.scl(scl), .sda_pull_n(sda_pull_n), .sda_line(sda_line), .rx_q(rx_q));

  always #2 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  // Register image as read over the bus
  function automatic logic [7:0] rd_exp(input logic [7:0] i);
    if (i == 8'h0B) return {6'h10, stp};
    if (i > 8'h03) return 8'h00;
    return (sh[i[1:0]] & WM[i[1:0]]) | FX[i[1:0]] | (i == 8'h01 ? {BW, 6'h00} : 8'h00);
  endfunction : rd_exp

  // Controls seen by the clock path
  function automatic logic [22:0] port_exp();
    logic [1:0] pm;
    logic [1:0] fs;
    pm = sh[1][5] ? sh[1][4:3] : BW;
    fs = sh[3][5] ? sh[3][4:3] : 2'h0;
    return {{sh[0][7:6], sh[0][4:2], sh[0][0]} & ~pins_n, sh[2][7:6], sh[2][4:2], sh[2][0], sh[3][0],
            sh[1][1:0], pm, sh[3][5], fs, stp == 2'h1, stp == 2'h2, stp == 2'h3};
  endfunction : port_exp

  task automatic cmp_bus(input logic [8:0] e, input logic [8:0] a);
    num_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR bus t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : cmp_bus

  task automatic cmp_port(input logic [22:0] e, input logic [22:0] a);
    num_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR port t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : cmp_port

  // Results taken off the queues as they appear
  always @(host.rx_done) cmp_bus(exp_bus.pop_front(), rx_q);
  always @(snap) cmp_port(exp_port.pop_front(), {active, speed, fb, swing, pll, fv, fsel, s_hz, s_th, s_ch});

  task automatic bus(input logic [7:0] d, input logic hb, input logic [8:0] e);
    exp_bus.push_back(e);
    host.xfer({d, hb});
  endtask : bus

  task automatic wr_blk(input logic [7:0] n, input logic [7:0] x, input int cnt);
    host.start();
    bus({tgt, 1'b0}, 1'b1, {tgt, 1'b0, 1'b0});
    bus(n, 1'b1, {n, 1'b0});
    bus(x, 1'b1, {x, 1'b0});
    for (int i = 0; i < cnt; i++) bus(wbuf[i], 1'b1, {wbuf[i], 1'b0});
    host.stop();
  endtask : wr_blk

  task automatic rd_blk(input logic [7:0] n, input int cnt);
    host.start();
    bus({tgt, 1'b0}, 1'b1, {tgt, 1'b0, 1'b0});
    bus(n, 1'b1, {n, 1'b0});
    host.start();
    bus({tgt, 1'b1}, 1'b1, {tgt, 1'b1, 1'b0});
    bus(8'hFF, 1'b0, {scbc_pkg::READ_COUNT, 1'b0});
    for (int i = 0; i < cnt; i++) bus(8'hFF, i == cnt - 1, {rd_exp(n + 8'(i)), i == cnt - 1});
    host.stop();
  endtask : rd_blk

  // Pins and registers need a few cycles to pass the synchronisers
  task automatic snap_chk();
    repeat (8) @(negedge mclk);
    exp_port.push_back(port_exp());
    -> snap;
  endtask : snap_chk

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Hang guard, about 30 percent above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    pins_n = 6'h00;
    adr_s = 2'h1;
    tgt = 7'h69;
    rng = 32'hE00A;
    sh = '{8'hDD, 8'h02, 8'hDD, 8'h01};
    stp = 2'h0;
    repeat (12) @(posedge mclk);
    @(negedge mclk) reset = 1'b0;
    repeat (20) @(negedge mclk);
    snap_chk();
    rd_blk(8'h00, 4);
    // Every stop code and both override settings, random data and pins
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) wbuf[j] = 8'(rnd());
      wbuf[1][5] = k[0];
      wbuf[3][5] = k[1];
      wr_blk(8'h00, 8'h04, 4);
      sh = wbuf;
      wbuf[0] = {6'h00, k[1:0]};
      wr_blk(8'h0B, 8'h01, 1);
      stp = k[1:0];
      @(negedge mclk) pins_n = 6'(rnd());
      snap_chk();
      rd_blk(8'h00, 4);
      rd_blk(8'h0B, 1);
    end
    // Another target's address is left unanswered
    host.start();
    bus(8'hD0, 1'b1, 9'h1A1);
    host.stop();
    // A byte beyond the count is acked but dropped
    wbuf[0] = 8'(rnd());
    wbuf[1] = ~sh[3];
    wr_blk(8'h02, 8'h01, 2);
    sh[2] = wbuf[0];
    rd_blk(8'h02, 3);
    snap_chk();
    // Power up again on the high strap; the old address must now go unanswered
    @(negedge mclk) reset = 1'b1;
    adr_s = 2'h2;
    sh = '{8'hDD, 8'h02, 8'hDD, 8'h01};
    stp = 2'h0;
    tgt = 7'h6A;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    repeat (20) @(negedge mclk);
    snap_chk();
    host.start();
    bus(8'hD2, 1'b1, 9'h1A5);
    host.stop();
    rd_blk(8'h00, 4);
    wrap_up();
  end
endmodule : tb_smbus_clock_buffer_config
